// file: core/spi_port_defs.vh
// constants for the serial register port: command fields, register
// addresses, register widths and write-buffer sizing
// assumes it is included by its bare name from the design file
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH

// command byte fields
`define CMD_ADDR_MSB      7
`define CMD_ADDR_LSB      3
`define CMD_READ_BIT      2
`define CMD_LAST_BIT      3'h7

// output register addresses
`define ADDR_CURRENT      5'h00
`define ADDR_VOLT_ONE     5'h01
`define ADDR_VOLT_TWO     5'h02
`define ADDR_SAMPLE_CRC   5'h03
`define ADDR_STATUS_ZERO  5'h04
`define ADDR_CNT_SNAP     5'h05

// register widths in bits
`define WIDTH_24          6'h18
`define WIDTH_16          6'h10
`define WIDTH_8           6'h08

// reset values
`define RESET_BYTE        8'h00
`define RESET_WORD        32'h0000_0000

// write buffer: address plus data byte, sixteen deep
`define WBUF_WIDTH        13
`define WBUF_DEPTH        16
`define WBUF_AW           4

`endif

// file: core/spi_register_port.v
// serial register port of a three channel metering converter, plus the
// buffer that carries accepted register writes to the core
// assumes sclk, cs_n and mosi are already synchronous to ref_clk and
// that ref_clk is far faster than sclk, so edges are found by sampling
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defs.vh"

////////////////////////////////////////////////////////////////////////////
// first-in first-out buffer with a registered output stage
module wr_fifo #(
   parameter WIDTH = 13,
   parameter DEPTH = 16,
   parameter AW    = 4
)(
   // clock and reset
   input  wire             ref_clk,
   input  wire             rst,
   // filling side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // draining side
   output reg              out_valid_q,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data_q
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;

   // full is honest: stored words only, output stage counted apart
   assign in_ready = (count_q != DEPTH[AW:0]);
   assign push     = in_valid && in_ready;
   assign pop      = (count_q != {(AW+1){1'b0}})
                     && (!out_valid_q || out_ready);

   // storage array, written without reset
   always @(posedge ref_clk)
   begin
      if (push)
         mem[wr_ptr_q] <= in_data;
   end

   // pointers, fill count and output stage
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_ptr_q    <= {AW{1'b0}};
         rd_ptr_q    <= {AW{1'b0}};
         count_q     <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
         out_data_q  <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
         begin
            rd_ptr_q    <= rd_ptr_q + 1'b1;
            out_data_q  <= mem[rd_ptr_q];
            out_valid_q <= 1'b1;
         end
         else if (out_ready)
            out_valid_q <= 1'b0;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end

endmodule

////////////////////////////////////////////////////////////////////////////
// serial slave: command decode, single and burst reads, byte writes
module spi_register_port (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // serial pins
   input  wire        sclk,
   input  wire        cs_n,
   input  wire        mosi,
   output reg         miso_q,
   output reg         miso_oe_n_q,
   // converter side values shown through the output registers
   input  wire [23:0] current_sample,
   input  wire [23:0] voltage_one_sample,
   input  wire [23:0] voltage_two_sample,
   input  wire [15:0] sample_crc,
   input  wire [7:0]  status_zero,
   input  wire [15:0] counter_snapshot,
   // accepted register writes toward the core
   output wire        wr_valid_q,
   input  wire        wr_ready,
   output wire [4:0]  wr_addr_q,
   output wire [7:0]  wr_data_q,
   output reg         wr_drop_q
);

   localparam [1:0] ST_CMD  = 2'h0;
   localparam [1:0] ST_RD   = 2'h1;
   localparam [1:0] ST_WR   = 2'h2;
   localparam [1:0] ST_DONE = 2'h3;

   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg         sclk_q;
   reg  [2:0]  bit_q;
   reg  [2:0]  bit_d;
   reg  [7:0]  cmd_q;
   reg  [7:0]  cmd_d;
   reg  [4:0]  addr_q;
   reg  [4:0]  addr_d;
   reg  [31:0] shift_q;
   reg  [31:0] shift_d;
   reg  [5:0]  left_q;
   reg  [5:0]  left_d;
   reg         miso_d;
   reg         miso_oe_n_d;
   reg  [7:0]  wreg [0:31];
   reg  [4:0]  sel_addr;
   reg  [31:0] sel_value;
   reg         push;
   wire        buf_ready;
   wire        sclk_rise;
   wire        sclk_fall;
   wire [7:0]  cmd_full;

   // bit count of each address; writable bytes take the default
   function [5:0] reg_width;
      input [4:0] a;
      begin
         case (a)
            `ADDR_CURRENT:     reg_width = `WIDTH_24;
            `ADDR_VOLT_ONE:    reg_width = `WIDTH_24;
            `ADDR_VOLT_TWO:    reg_width = `WIDTH_24;
            `ADDR_SAMPLE_CRC:  reg_width = `WIDTH_16;
            `ADDR_STATUS_ZERO: reg_width = `WIDTH_8;
            `ADDR_CNT_SNAP:    reg_width = `WIDTH_16;
            default:           reg_width = `WIDTH_8;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // edge detection on the sampled serial clock
   // rising edge samples
   assign sclk_rise = sclk && !sclk_q;
   assign sclk_fall = !sclk && sclk_q;
   assign cmd_full  = {cmd_q[6:0], mosi};

   ////////////////////////////////////////////////////////////////////////
   // value to load into the output shifter, left aligned so that the
   // top bit always leaves first whatever the register width
   always @*
   begin
      sel_addr = (state_q == ST_CMD) ? cmd_full[`CMD_ADDR_MSB:`CMD_ADDR_LSB]
                                     : addr_q + 5'h01;
      case (sel_addr)
         `ADDR_CURRENT:     sel_value = {current_sample, 8'h00};
         `ADDR_VOLT_ONE:    sel_value = {voltage_one_sample, 8'h00};
         `ADDR_VOLT_TWO:    sel_value = {voltage_two_sample, 8'h00};
         `ADDR_SAMPLE_CRC:  sel_value = {sample_crc, 16'h0000};
         `ADDR_STATUS_ZERO: sel_value = {status_zero, 24'h000000};
         `ADDR_CNT_SNAP:    sel_value = {counter_snapshot, 16'h0000};
         default:           sel_value = {wreg[sel_addr], 24'h000000};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer state machine
   always @*
   begin
      state_d     = state_q;
      bit_d       = bit_q;
      cmd_d       = cmd_q;
      addr_d      = addr_q;
      shift_d     = shift_q;
      left_d      = left_q;
      miso_d      = miso_q;
      miso_oe_n_d = miso_oe_n_q;
      push        = 1'b0;
      if (cs_n)
      begin
         state_d     = ST_CMD;
         bit_d       = 3'h0;
         miso_oe_n_d = 1'b1;
      end
      else
      begin
         case (state_q)
            ST_CMD:
            begin
               if (sclk_rise)
               begin
                  cmd_d = cmd_full;
                  bit_d = bit_q + 3'h1;
                  if (bit_q == `CMD_LAST_BIT)
                  begin
                     addr_d = cmd_full[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                     bit_d  = 3'h0;
                     if (cmd_full[`CMD_READ_BIT])
                     begin
                        state_d = ST_RD;
                        shift_d = sel_value;
                        left_d  = reg_width(sel_addr);
                     end
                     else
                        state_d = ST_WR;
                  end
               end
            end
            ST_RD:
            begin
               if (sclk_fall)
               begin
                  miso_d      = shift_q[31];
                  miso_oe_n_d = 1'b0;
                  if (left_q == 6'h01)
                  begin
                     addr_d  = sel_addr;
                     shift_d = sel_value;
                     left_d  = reg_width(sel_addr);
                  end
                  else
                  begin
                     shift_d = {shift_q[30:0], 1'b0};
                     left_d  = left_q - 6'h01;
                  end
               end
            end
            ST_WR:
            begin
               // one data byte follows the command
               if (sclk_rise)
               begin
                  cmd_d = cmd_full;
                  bit_d = bit_q + 3'h1;
                  if (bit_q == `CMD_LAST_BIT)
                  begin
                     push    = 1'b1;
                     state_d = ST_DONE;
                  end
               end
            end
            ST_DONE:
            begin
               // extra clocks after the byte are ignored until deselect
               state_d = ST_DONE;
            end
            default:
            begin
               state_d = ST_CMD;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_q     <= ST_CMD;
         sclk_q      <= 1'b1;
         bit_q       <= 3'h0;
         cmd_q       <= `RESET_BYTE;
         addr_q      <= 5'h00;
         shift_q     <= `RESET_WORD;
         left_q      <= 6'h00;
         miso_q      <= 1'b0;
         miso_oe_n_q <= 1'b1;
         wr_drop_q   <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         sclk_q      <= sclk;
         bit_q       <= bit_d;
         cmd_q       <= cmd_d;
         addr_q      <= addr_d;
         shift_q     <= shift_d;
         left_q      <= left_d;
         miso_q      <= miso_d;
         miso_oe_n_q <= miso_oe_n_d;
         // a full buffer loses the byte; flagged for one cycle
         wr_drop_q   <= push && !buf_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writable bytes: kept locally so that reads return them, and only
   // when the buffer takes them, so the core and readback never differ
   // only a complete write lands
   always @(posedge ref_clk)
   begin
      if (push && buf_ready)
         wreg[addr_q] <= cmd_full;
   end

   ////////////////////////////////////////////////////////////////////////
   // write buffer toward the core; the core may stall it until full
   wr_fifo #(
      .WIDTH (`WBUF_WIDTH),
      .DEPTH (`WBUF_DEPTH),
      .AW    (`WBUF_AW)
   ) u_wr_fifo (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .in_valid    (push),
      .in_ready    (buf_ready),
      .in_data     ({addr_q, cmd_full}),
      .out_valid_q (wr_valid_q),
      .out_ready   (wr_ready),
      .out_data_q  ({wr_addr_q, wr_data_q})
   );

endmodule
`default_nettype wire

// file: verification/spi_port_props.sv
// checker for the serial register port, bound to its top module
// assumes ref_clk sampling of sclk and cs_n, sync active high rst
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module spi_port_props (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // serial pins
   input wire logic       sclk,
   input wire logic       cs_n,
   input wire logic       miso_q,
   input wire logic       miso_oe_n_q,
   // write buffer
   input wire logic       wr_valid_q,
   input wire logic       wr_ready,
   input wire logic [4:0] wr_addr_q,
   input wire logic [7:0] wr_data_q,
   input wire logic       wr_drop_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // serial output side
   hiz_when_idle_a:
      assert property (cs_n [*3] |-> miso_oe_n_q)
      else $error("miso driven while deselected");
   change_on_fall_a:
      assert property (!miso_oe_n_q && !cs_n && $changed(miso_q) |-> !sclk)
      else $error("miso changed while sclk high");
   first_bit_fall_a:
      assert property ($fell(miso_oe_n_q) |-> !sclk && !cs_n)
      else $error("miso drive began off a falling edge");
   reset_quiet_a:
      assert property (disable iff (1'b0)
         rst |=> miso_oe_n_q && !wr_valid_q && !wr_drop_q)
      else $error("outputs active after reset");

   // write buffer side
   push_in_frame_a:
      assert property ($rose(wr_valid_q) |-> $past(sclk, 2) && !$past(cs_n, 2))
      else $error("write word outside a clocked frame");
   drop_when_full_a:
      assert property (wr_drop_q |-> wr_valid_q)
      else $error("drop with empty buffer");
   drop_one_cycle_a:
      assert property (wr_drop_q |=> !wr_drop_q)
      else $error("drop flag longer than one cycle");
   word_held_a:
      assert property (wr_valid_q && !wr_ready |=>
         wr_valid_q && $stable({wr_addr_q, wr_data_q}))
      else $error("write word changed before taken");

   cover property ($fell(miso_oe_n_q));
   cover property (wr_drop_q);
   cover property (wr_valid_q && wr_ready);
endmodule

bind spi_register_port spi_port_props spi_port_props_i (
   .ref_clk, .rst, .sclk, .cs_n, .miso_q, .miso_oe_n_q,
   .wr_valid_q, .wr_ready, .wr_addr_q, .wr_data_q, .wr_drop_q);
`default_nettype wire

// file: verification/spi_host_model.sv
// host side serial master that frames commands and data bytes
// assumes the bench resolves the miso line and calls xfer in turn
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module spi_host_model (
   // clock
   input  wire logic ref_clk,
   // serial pins
   input  wire logic miso,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi
);
   // 5 mhz sclk, twenty ref_clk per phase
   localparam int HALF = 20;

   // idle high clock and deselected at time zero
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // all pin changes land just after a ref_clk edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // command byte then n bits; a short n is an aborted frame
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                       input int n, output logic [127:0] rd);
      logic [15:0] tx;
      tx = {cmd, wd};
      rd = '0;
      step(1);
      // select held over the whole frame
      cs_n = 1'b0;
      for (int i = 0; i < 8 + n; i++)
      begin
         step(HALF);
         // mosi moves on falls, msb first
         sclk = 1'b0;
         mosi = (i < 16) ? tx[15 - i] : 1'b0;
         step(HALF);
         if (i >= 8)
            rd = {rd[126:0], miso};
         sclk = 1'b1;
      end
      step(HALF);
      // end of frame, line left not at its last value
      cs_n = 1'b1;
      mosi = ~mosi;
      step(4);
   endtask
endmodule
`default_nettype wire

// file: verification/spi_register_port_tb.sv
// bench for the serial register port: reads, bursts, writes, abort
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module spi_register_port_tb;
   logic            ref_clk = 1'b0;
   logic            rst = 1'b1;
   logic            wr_ready = 1'b0;
   logic [111:0]    smp = 112'h123456_abcdef_0f1e2d_beef_5a_c3a5;
   logic            last_m = 1'b0;
   logic [127:0]    rd;
   logic [12:0]     got_q[$];
   int              bad_count = 0;
   int              checks_done = 0;
   int              drops = 0;
   wire logic       sclk, cs_n, mosi, miso_q, miso_oe_n_q, miso_line;
   wire logic       wr_valid_q, wr_drop_q;
   wire logic [4:0] wr_addr_q;
   wire logic [7:0] wr_data_q;

   always #2.5 ref_clk = ~ref_clk;

   // released miso shows the inverse of its last driven bit
   always @(posedge ref_clk)
      if (!miso_oe_n_q)
         last_m <= miso_q;
   assign miso_line = miso_oe_n_q ? ~last_m : miso_q;

   // collect words taken from the buffer and count drops
   always @(posedge ref_clk)
   begin
      if (!rst && wr_valid_q && wr_ready)
         got_q.push_back({wr_addr_q, wr_data_q});
      if (!rst && wr_drop_q)
         drops++;
   end

   spi_register_port spi_register_port_i (
      .ref_clk, .rst, .sclk, .cs_n, .mosi, .miso_q, .miso_oe_n_q,
      .current_sample(smp[111:88]), .voltage_one_sample(smp[87:64]),
      .voltage_two_sample(smp[63:40]), .sample_crc(smp[39:24]),
      .status_zero(smp[23:16]), .counter_snapshot(smp[15:0]),
      .wr_valid_q, .wr_ready, .wr_addr_q, .wr_data_q, .wr_drop_q);

   spi_host_model spi_host_model_i (
      .ref_clk, .miso(miso_line), .sclk, .cs_n, .mosi);

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [127:0] e,
                      input logic [127:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] cmd,
                         input int n, input logic [127:0] e);
      spi_host_model_i.xfer(cmd, 8'h00, n, rd);
      chk(nm, e, rd);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (20) @(posedge ref_clk);
      #1 rst = 1'b0;
      rd = '1;
      for (int i = 0; i < 4 && rd[0] !== 1'b0; i++)
         spi_host_model_i.xfer(8'h24, 8'h00, 8, rd);
      chk("status", 128'(smp[23:16]), rd);
      rd_chk("single v1", 8'h0c, 24, 128'(smp[87:64]));
      rd_chk("burst all", 8'h04, 112, 128'(smp));
      smp = ~smp;
      rd_chk("burst v1", 8'h0f, 72, 128'(smp[87:16]));
      rd_chk("cut read", 8'h04, 10, 128'(smp[111:102]));
      $display("test reads done");
      spi_host_model_i.xfer(8'h39, 8'ha5, 8, rd);
      spi_host_model_i.xfer(8'h38, 8'h3c, 4, rd);
      rd_chk("readback", 8'h3c, 8, 128'h0a5);
      for (int i = 0; i < 17; i++)
         spi_host_model_i.xfer(8'h40, 8'(i), 8, rd);
      rd_chk("last kept", 8'h44, 8, 128'h0f);
      chk("drops", 128'd1, 128'(drops));
      repeat (40) @(posedge ref_clk) #1 wr_ready = ~wr_ready;
      chk("taken", 128'd17, 128'(got_q.size()));
      for (int i = 0; i < got_q.size(); i++)
         chk("word", (i == 0) ? 128'h7a5 : 128'h800 + i - 1,
             128'(got_q[i]));
      $display("test writes done");
      tally_and_finish();
   end

   // watchdog well beyond the expected run length
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
